/* File: rtl/tsc_defines.svh */
// Constants for the task switch control block.
// Assumes inclusion by bare name from the design module.
`ifndef TSC_DEFINES_SVH
`define TSC_DEFINES_SVH
`define TSC_TSEG_MIN_LIMIT 16'h002b
`define TSC_NEST_BIT 4'he
`define TSC_TYPE_AVAIL 4'h1
`define TSC_TYPE_BUSY 4'h3
`define TSC_VEC_NOEXT 8'h07
`define TSC_VEC_DOUBLE 8'h08
`define TSC_VEC_GP 8'h0d
`define TSC_RESET_CS 16'hf000
`define TSC_RESET_IP 16'hfff0
`define TSC_STW_PROT 2'h0
`define TSC_STW_PRES 2'h1
`define TSC_STW_SWITCHED 2'h3
`endif

/* File: rtl/tsc_pkg.sv */
// Types shared by the task switch control block.
// Assumes the defines header is on the include path.
package tsc_pkg;
  // Source that starts a task switch.
  typedef enum logic [2:0] {
    TSC_SRC_JMP = 3'b000,
    TSC_SRC_CALL = 3'b001,
    TSC_SRC_SWINT = 3'b010,
    TSC_SRC_EXC = 3'b011,
    TSC_SRC_EXTINT = 3'b100,
    TSC_SRC_RETURN = 3'b101
  } tsc_src_t;
  // Selector test operation codes.
  typedef enum logic [2:0] {
    TSC_OP_NONE = 3'b000,
    TSC_OP_ADJ = 3'b001,
    TSC_OP_VRD = 3'b010,
    TSC_OP_VWR = 3'b011,
    TSC_OP_LIM = 3'b100,
    TSC_OP_RIGHTS = 3'b101
  } tsc_op_t;
  // Fault tracking state.
  typedef enum logic [1:0] {
    TSC_FS_RUN = 2'b00,
    TSC_FS_DOUBLE = 2'b01,
    TSC_FS_SHUT = 2'b10
  } tsc_fstate_t;
  // Descriptor of the segment a selector references.
  typedef struct packed {
    logic [23:0] base;
    logic [15:0] limit;
    logic [7:0] rights;
  } tsc_desc_t;
  // Task switch request.
  typedef struct packed {
    logic valid;
    tsc_src_t src;
    logic gate_in_table;
    logic [15:0] sel;
    tsc_desc_t desc;
  } tsc_switch_req_t;
  // Selector test request.
  typedef struct packed {
    tsc_op_t op;
    logic [15:0] sel;
    logic [15:0] reg_val;
    tsc_desc_t desc;
    logic priv_ok;
    logic type_ok;
    logic readable;
    logic writable;
  } tsc_test_req_t;
  // Selector test result.
  typedef struct packed {
    logic done;
    logic zf;
    logic [15:0] result;
  } tsc_test_rsp_t;
endpackage : tsc_pkg

/* File: rtl/tsc_task_switch_control.sv */
// Task switch, lazy extension context, selector tests, double fault and reset-time addressing.
// Assumes one 10 MHz clock, synchronous reset, and a sequencer that performs memory writes it is told to.
`timescale 1ns/1ps
`default_nettype none
`include "tsc_defines.svh"

// What this block does
// - Start a switch for jump or call to segment or gate, or interrupt task gate.
// - Save current state, load new task state, continue in the new task.
// - Task segment limit must exceed 002B to be valid.
// - Hold current task selector; reload hidden base and limit on each new selector.
// - Nested flag at flag bit 14; interrupt return switches back when set.
// - Call or software interrupt switch marks both busy and stores back link.
// - Set nested flag on call or interrupt switch; clear on plain interrupt.
// - Mark busy by rewriting descriptor type from available to busy value.
// - Raise exception 13 when a selector references a busy task segment.
// - Leave extension context untouched on a switch; change only on use.
// - Set task switched flag in the status word on every switch.
// - Exception 7 on escape or wait when switched and present flags set.
// - Privilege adjust takes maximum requested field; zero flag if it changed.
// - Read and write verify set zero flag when access allowed, no exception.
// - Limit and rights load copy value only when allowed; zero flag on success.
// - Two exceptions in one instruction give double fault exception 8.
// - Exception during double fault enters shutdown; no further switches or exceptions processed.
// - Leave shutdown by NMI keeping protected mode, or reset leaving it.
// - Signal shutdown with a halt bus operation driving address bit 1 high.
// - After reset real mode; code fetch upper address high until code reloaded.
// - Start after reset at code F000 and pointer FFF0.
module tsc_task_switch_control (
  input wire logic clk,
  input wire logic srst,
  input wire tsc_pkg::tsc_switch_req_t switch_req,
  input wire logic plain_int,
  input wire logic target_busy,
  input wire logic [15:0] flag_write_val,
  input wire logic flag_write,
  input wire logic [3:0] status_word_load_val,
  input wire logic status_word_load_op,
  input wire logic ext_op,
  input wire logic exception_in,
  input wire logic nmi,
  input wire logic cs_load,
  input wire logic [1:0] seg_sel,
  input wire tsc_pkg::tsc_test_req_t test_req,
  output logic switch_go,
  output logic switch_back,
  output logic mark_old_busy,
  output logic mark_new_busy,
  output logic [3:0] busy_type,
  output logic write_back_link,
  output logic [15:0] back_link,
  output logic [15:0] task_selector_register,
  output logic [23:0] task_base,
  output logic [15:0] task_limit,
  output logic nested_task_flag,
  output logic [3:0] machine_status_word,
  output logic exc_valid,
  output logic [7:0] exc_vector,
  output logic shutdown,
  output logic halt_cycle,
  output logic halt_a1,
  output logic [3:0] upper_addr,
  output logic [15:0] cs_value,
  output logic [15:0] ip_value,
  output tsc_pkg::tsc_test_rsp_t test_rsp
);

  logic [15:0] tsel_q, tsel_d, link_q, link_d;
  logic [23:0] base_q, base_d;
  logic [15:0] limit_q, limit_d;
  logic nest_q, nest_d, go_q, go_d, back_q, back_d, mob_q, mob_d, mnb_q, mnb_d, wbl_q, wbl_d;
  logic [3:0] stw_q, stw_d;
  logic exv_q, exv_d, cs_fresh_q, cs_fresh_d, nmi_m, nmi_s;
  logic [7:0] vec_q, vec_d;
  logic [3:0] ua_q, ua_d;
  tsc_pkg::tsc_fstate_t fs_q, fs_d;
  tsc_pkg::tsc_test_rsp_t rsp_q, rsp_d;
  logic sw_ok, link_sw, pend;

  //////////////////////////////////////////////////////////////////////////////
  // Task switch, selector register and status word next state.
  always_comb begin
    tsel_d = tsel_q;
    base_d = base_q;
    limit_d = limit_q;
    link_d = link_q;
    nest_d = nest_q;
    stw_d = stw_q;
    go_d = 1'b0;
    back_d = 1'b0;
    mob_d = 1'b0;
    mnb_d = 1'b0;
    wbl_d = 1'b0;
    link_sw = (switch_req.src == tsc_pkg::TSC_SRC_CALL) || (switch_req.src == tsc_pkg::TSC_SRC_SWINT);
    // A switch needs a valid limit, an idle target and a running machine.
    sw_ok = switch_req.valid && switch_req.gate_in_table && !target_busy && fs_q != tsc_pkg::TSC_FS_SHUT
      && switch_req.desc.limit > `TSC_TSEG_MIN_LIMIT
      && (switch_req.src != tsc_pkg::TSC_SRC_RETURN || nest_q);
    if (flag_write) begin
      nest_d = flag_write_val[`TSC_NEST_BIT];
    end
    if (plain_int) begin
      nest_d = 1'b0;
    end
    if (status_word_load_op) begin
      stw_d = status_word_load_val | {3'h0, stw_q[`TSC_STW_PROT]};
    end
    if (sw_ok) begin
      go_d = 1'b1;
      back_d = (switch_req.src == tsc_pkg::TSC_SRC_RETURN);
      tsel_d = switch_req.sel;
      base_d = switch_req.desc.base;
      limit_d = switch_req.desc.limit;
      stw_d[`TSC_STW_SWITCHED] = 1'b1;
      if (link_sw) begin
        mob_d = 1'b1;
        mnb_d = 1'b1;
        wbl_d = 1'b1;
        link_d = tsel_q;
      end
      nest_d = link_sw || switch_req.src == tsc_pkg::TSC_SRC_EXC || switch_req.src == tsc_pkg::TSC_SRC_EXTINT;
    end
  end

  // Registers for the task switch group.
  always_ff @(posedge clk) begin
    if (srst) begin
      tsel_q <= 16'h0000;
      base_q <= 24'h000000;
      limit_q <= 16'h0000;
      link_q <= 16'h0000;
      nest_q <= 1'b0;
      stw_q <= 4'h0;
      go_q <= 1'b0;
      back_q <= 1'b0;
      mob_q <= 1'b0;
      mnb_q <= 1'b0;
      wbl_q <= 1'b0;
    end else begin
      tsel_q <= tsel_d;
      base_q <= base_d;
      limit_q <= limit_d;
      link_q <= link_d;
      nest_q <= nest_d;
      stw_q <= stw_d;
      go_q <= go_d;
      back_q <= back_d;
      mob_q <= mob_d;
      mnb_q <= mnb_d;
      wbl_q <= wbl_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Non-maskable interrupt pin synchroniser.
  always_ff @(posedge clk) begin
    if (srst) begin
      nmi_m <= 1'b0;
      nmi_s <= 1'b0;
    end else begin
      nmi_m <= nmi;
      nmi_s <= nmi_m;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Exception, double fault and shutdown next state.
  always_comb begin
    fs_d = fs_q;
    exv_d = 1'b0;
    vec_d = vec_q;
    pend = switch_req.valid && target_busy;
    case (fs_q)
      tsc_pkg::TSC_FS_RUN: begin
        if (exception_in && pend) begin
          exv_d = 1'b1;
          vec_d = `TSC_VEC_DOUBLE;
          fs_d = tsc_pkg::TSC_FS_DOUBLE;
        end else if (pend) begin
          exv_d = 1'b1;
          vec_d = `TSC_VEC_GP;
        end else if (ext_op && stw_q[`TSC_STW_SWITCHED] && stw_q[`TSC_STW_PRES]) begin
          exv_d = 1'b1;
          vec_d = `TSC_VEC_NOEXT;
        end
      end
      tsc_pkg::TSC_FS_DOUBLE: begin
        if (exception_in || pend) begin
          fs_d = tsc_pkg::TSC_FS_SHUT;
        end else begin
          fs_d = tsc_pkg::TSC_FS_RUN;
        end
      end
      tsc_pkg::TSC_FS_SHUT: begin
        if (nmi_s) begin
          fs_d = tsc_pkg::TSC_FS_RUN;
        end
      end
      default: fs_d = tsc_pkg::TSC_FS_RUN;
    endcase
  end

  // Registers for the fault group; reset also leaves protected mode through the status word.
  always_ff @(posedge clk) begin
    if (srst) begin
      fs_q <= tsc_pkg::TSC_FS_RUN;
      exv_q <= 1'b0;
      vec_q <= 8'h00;
    end else begin
      fs_q <= fs_d;
      exv_q <= exv_d;
      vec_q <= vec_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Upper address bits for real mode start-up.
  always_comb begin
    cs_fresh_d = cs_fresh_q;
    if (cs_load) begin
      cs_fresh_d = 1'b0;
    end
    ua_d = (cs_fresh_d && seg_sel == 2'h1) ? 4'hf : 4'h0;
  end

  // Registers for the address group.
  always_ff @(posedge clk) begin
    if (srst) begin
      cs_fresh_q <= 1'b1;
      ua_q <= 4'h0;
    end else begin
      cs_fresh_q <= cs_fresh_d;
      ua_q <= ua_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Selector test operations; none raises an exception.
  always_comb begin
    rsp_d.done = test_req.op != tsc_pkg::TSC_OP_NONE;
    rsp_d.zf = 1'b0;
    rsp_d.result = 16'h0000;
    case (test_req.op)
      tsc_pkg::TSC_OP_ADJ: begin
        rsp_d.result = test_req.sel;
        if (test_req.reg_val[1:0] > test_req.sel[1:0]) begin
          rsp_d.result[1:0] = test_req.reg_val[1:0];
          rsp_d.zf = 1'b1;
        end
      end
      tsc_pkg::TSC_OP_VRD: rsp_d.zf = test_req.readable;
      tsc_pkg::TSC_OP_VWR: rsp_d.zf = test_req.writable;
      tsc_pkg::TSC_OP_LIM: begin
        if (test_req.priv_ok && test_req.type_ok) begin
          rsp_d.result = test_req.desc.limit;
          rsp_d.zf = 1'b1;
        end
      end
      tsc_pkg::TSC_OP_RIGHTS: begin
        if (test_req.priv_ok) begin
          rsp_d.result = {test_req.desc.rights, 8'h00};
          rsp_d.zf = 1'b1;
        end
      end
      default: rsp_d.done = 1'b0;
    endcase
  end

  // Register for the test result.
  always_ff @(posedge clk) begin
    if (srst) begin
      rsp_q <= '0;
    end else begin
      rsp_q <= rsp_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs.
  assign switch_go = go_q;
  assign switch_back = back_q;
  assign mark_old_busy = mob_q;
  assign mark_new_busy = mnb_q;
  assign busy_type = `TSC_TYPE_BUSY;
  assign write_back_link = wbl_q;
  assign back_link = link_q;
  assign task_selector_register = tsel_q;
  assign task_base = base_q;
  assign task_limit = limit_q;
  assign nested_task_flag = nest_q;
  assign machine_status_word = stw_q;
  assign exc_valid = exv_q;
  assign exc_vector = vec_q;
  assign shutdown = (fs_q == tsc_pkg::TSC_FS_SHUT);
  assign halt_cycle = shutdown;
  assign halt_a1 = shutdown;
  assign upper_addr = ua_q;
  assign cs_value = `TSC_RESET_CS;
  assign ip_value = `TSC_RESET_IP;
  assign test_rsp = rsp_q;

  //////////////////////////////////////////////////////////////////////////////
  // Checks.
  AST_LIMIT: assert property (@(posedge clk) disable iff (srst)
    switch_go |-> task_limit > `TSC_TSEG_MIN_LIMIT) else $error("Switch with short limit.");
  AST_TR_LOAD: assert property (@(posedge clk) disable iff (srst)
    (switch_req.valid && !target_busy && switch_req.gate_in_table && switch_req.desc.limit > 16'h002b
     && switch_req.src == tsc_pkg::TSC_SRC_JMP && !shutdown) |=> task_selector_register == $past(switch_req.sel))
    else $error("Selector not loaded.");
  AST_SWITCHED_SET: assert property (@(posedge clk) disable iff (srst)
    switch_go |-> machine_status_word[3]) else $error("Switched flag not set.");
  AST_LINK: assert property (@(posedge clk) disable iff (srst)
    write_back_link |-> mark_old_busy && mark_new_busy && back_link == $past(task_selector_register))
    else $error("Bad back link.");
  AST_NEST: assert property (@(posedge clk) disable iff (srst)
    mark_new_busy |-> nested_task_flag) else $error("Nested flag not set.");
  AST_BUSY_EXC: assert property (@(posedge clk) disable iff (srst)
    (switch_req.valid && target_busy && !exception_in && fs_q == tsc_pkg::TSC_FS_RUN)
    |=> exc_valid && exc_vector == 8'h0d) else $error("Busy use not trapped.");
  AST_NOEXT: assert property (@(posedge clk) disable iff (srst)
    (ext_op && machine_status_word[3] && machine_status_word[1] && !switch_req.valid && fs_q == tsc_pkg::TSC_FS_RUN)
    |=> exc_vector == 8'h07) else $error("Missing exception 7.");
  AST_SHUT: assert property (@(posedge clk) disable iff (srst)
    shutdown |-> halt_cycle && halt_a1 && !switch_go) else $error("Shutdown not signalled.");
  AST_ADJ: assert property (@(posedge clk) disable iff (srst)
    (test_req.op == tsc_pkg::TSC_OP_ADJ) |=> test_rsp.zf == ($past(test_req.reg_val[1:0]) > $past(test_req.sel[1:0])))
    else $error("Adjust flag wrong.");
  COV_SWITCH: cover property (@(posedge clk) disable iff (srst) switch_go && mark_new_busy);
  COV_BACK: cover property (@(posedge clk) disable iff (srst) switch_back);
  COV_SHUT: cover property (@(posedge clk) disable iff (srst) shutdown);

endmodule : tsc_task_switch_control
`default_nettype wire

/* File: verification/tsc_task_switch_control_test.sv */
// Self-checking testbench for the task switch control block.
// Assumes the package and defines header are compiled first; the bench drives every port itself.
`timescale 1ns/1ps
`default_nettype none
module tsc_task_switch_control_test;
  logic clk, srst, plain_int, target_busy, fw, swl, ext_op, exception_in, nmi, cs_load;
  logic switch_go, switch_back, mark_old_busy, mark_new_busy, write_back_link, nested_task_flag;
  logic exc_valid, shutdown, halt_cycle, halt_a1;
  logic [1:0] seg_sel;
  logic [3:0] swl_val, busy_type, stw, upper_addr;
  logic [7:0] exc_vector;
  logic [15:0] fw_val, back_link, tsr, task_limit, cs_value, ip_value;
  logic [23:0] task_base;
  tsc_pkg::tsc_switch_req_t sreq;
  tsc_pkg::tsc_test_req_t treq;
  tsc_pkg::tsc_test_rsp_t trsp;
  int num_errors = 0;
  int compares = 0;
  int cycles = 0;

  tsc_task_switch_control i_tsc_task_switch_control (.clk(clk), .srst(srst), .switch_req(sreq),
    .plain_int(plain_int), .target_busy(target_busy), .flag_write_val(fw_val), .flag_write(fw),
    .status_word_load_val(swl_val), .status_word_load_op(swl), .ext_op(ext_op), .exception_in(exception_in),
    .nmi(nmi), .cs_load(cs_load), .seg_sel(seg_sel), .test_req(treq), .switch_go(switch_go),
    .switch_back(switch_back), .mark_old_busy(mark_old_busy), .mark_new_busy(mark_new_busy),
    .busy_type(busy_type), .write_back_link(write_back_link), .back_link(back_link),
    .task_selector_register(tsr), .task_base(task_base), .task_limit(task_limit),
    .nested_task_flag(nested_task_flag), .machine_status_word(stw), .exc_valid(exc_valid),
    .exc_vector(exc_vector), .shutdown(shutdown), .halt_cycle(halt_cycle), .halt_a1(halt_a1),
    .upper_addr(upper_addr), .cs_value(cs_value), .ip_value(ip_value), .test_rsp(trsp));

  //////////////////////////////////////////////////////////////////////////////
  // Clock generation and a hang guard that ends the run.
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      num_errors++;
      complete_run();
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Shared helpers: comparison, verdict, single-cycle request drivers.
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : complete_run

  // Drives one switch request for one cycle; outputs are looked at after the answering edge.
  task automatic do_sw(input tsc_pkg::tsc_src_t s, input logic [15:0] sel, input logic [15:0] lim,
                       input logic busy, input logic exc);
    @(posedge clk);
    sreq <= '{valid: 1'b1, src: s, gate_in_table: 1'b1, sel: sel,
              desc: '{base: 24'h012340, limit: lim, rights: 8'h81}};
    target_busy <= busy;
    exception_in <= exc;
    @(posedge clk);
    sreq.valid <= 1'b0;
    target_busy <= 1'b0;
    exception_in <= 1'b0;
    #1;
  endtask : do_sw

  // Pulses one single-bit request selected by index for one cycle.
  task automatic pulse(input int which);
    @(posedge clk);
    case (which)
      0: plain_int <= 1'b1;
      1: fw <= 1'b1;
      2: swl <= 1'b1;
      3: ext_op <= 1'b1;
      4: exception_in <= 1'b1;
      default: cs_load <= 1'b1;
    endcase
    @(posedge clk);
    {plain_int, fw, swl, ext_op, exception_in, cs_load} <= 6'h00;
    #1;
  endtask : pulse

  // Issues one selector test and returns after its answer.
  task automatic do_test(input tsc_pkg::tsc_op_t op, input logic [15:0] sel, input logic [15:0] rv,
                         input logic [3:0] okbits);
    @(posedge clk);
    treq <= '{op: op, sel: sel, reg_val: rv, desc: '{base: 24'h000100, limit: 16'h1234, rights: 8'h93},
              priv_ok: okbits[3], type_ok: okbits[2], readable: okbits[1], writable: okbits[0]};
    @(posedge clk);
    treq.op <= tsc_pkg::TSC_OP_NONE;
    #1;
    chk("test done", 32'h1, {31'h0, trsp.done});
  endtask : do_test

  // Busy reference with a second exception, then a third exception while the double fault is handled.
  task automatic enter_shut();
    @(posedge clk);
    sreq <= '{valid: 1'b1, src: tsc_pkg::TSC_SRC_JMP, gate_in_table: 1'b1, sel: 16'h0040,
              desc: '{base: 24'h012340, limit: 16'h002c, rights: 8'h81}};
    target_busy <= 1'b1;
    exception_in <= 1'b1;
    @(posedge clk);
    sreq.valid <= 1'b0;
    target_busy <= 1'b0;
    #1;
    chk("double", 32'h108, {23'h0, exc_valid, exc_vector});
    @(posedge clk);
    exception_in <= 1'b0;
    #1;
    chk("shutdown", 32'h7, {29'h0, shutdown, halt_cycle, halt_a1});
  endtask : enter_shut

  //////////////////////////////////////////////////////////////////////////////
  // Scenarios.
  task automatic t_reset();
    chk("cs value", 32'h0000f000, {16'h0, cs_value});
    chk("ip value", 32'h0000fff0, {16'h0, ip_value});
    @(posedge clk);
    #1;
    chk("upper code", 32'hf, {28'h0, upper_addr});
    @(posedge clk);
    seg_sel <= 2'h0;
    @(posedge clk);
    #1;
    chk("upper data", 32'h0, {28'h0, upper_addr});
    pulse(5);
    @(posedge clk);
    seg_sel <= 2'h1;
    @(posedge clk);
    #1;
    chk("upper code reloaded", 32'h0, {28'h0, upper_addr});
    $display("test reset done");
  endtask : t_reset

  task automatic t_switch();
    do_sw(tsc_pkg::TSC_SRC_CALL, 16'h0028, 16'h002c, 1'b0, 1'b0);
    chk("go", 32'h1, {31'h0, switch_go});
    chk("busy marks", 32'h3, {30'h0, mark_old_busy, mark_new_busy});
    chk("link write", 32'h1, {31'h0, write_back_link});
    chk("selector", 32'h0028, {16'h0, tsr});
    chk("base limit", 32'h0123402c, {task_base, task_limit[7:0]});
    chk("nested", 32'h1, {31'h0, nested_task_flag});
    chk("switched", 32'h1, {31'h0, stw[3]});
    chk("busy type", 32'h3, {28'h0, busy_type});
    do_sw(tsc_pkg::TSC_SRC_SWINT, 16'h0030, 16'h0100, 1'b0, 1'b0);
    chk("back link", 32'h0028, {16'h0, back_link});
    do_sw(tsc_pkg::TSC_SRC_JMP, 16'h0038, 16'h002b, 1'b0, 1'b0);
    chk("short limit", 32'h0030, {switch_go, 15'h0, tsr});
    do_sw(tsc_pkg::TSC_SRC_JMP, 16'h0038, 16'h002c, 1'b0, 1'b0);
    chk("jump go", 32'h10038, {15'h0, switch_go, tsr});
    $display("test switch done");
  endtask : t_switch

  task automatic t_nested();
    @(posedge clk);
    fw_val <= 16'h4000;
    pulse(1);
    chk("pop set", 32'h1, {31'h0, nested_task_flag});
    pulse(0);
    chk("plain int", 32'h0, {31'h0, nested_task_flag});
    do_sw(tsc_pkg::TSC_SRC_RETURN, 16'h0028, 16'h002c, 1'b0, 1'b0);
    chk("return clear", 32'h0, {31'h0, switch_back});
    pulse(1);
    do_sw(tsc_pkg::TSC_SRC_RETURN, 16'h0028, 16'h002c, 1'b0, 1'b0);
    chk("return set", 32'h1, {31'h0, switch_back});
    pulse(1);
    @(posedge clk);
    fw_val <= 16'hbfff;
    pulse(1);
    chk("pop clear", 32'h0, {31'h0, nested_task_flag});
    $display("test nested done");
  endtask : t_nested

  task automatic t_ext();
    @(posedge clk);
    swl_val <= 4'ha;
    pulse(2);
    pulse(3);
    chk("ext fault", 32'h107, {23'h0, exc_valid, exc_vector});
    @(posedge clk);
    swl_val <= 4'h8;
    pulse(2);
    pulse(3);
    chk("ext absent", 32'h0, {31'h0, exc_valid});
    $display("test extension done");
  endtask : t_ext

  task automatic t_ptr();
    do_test(tsc_pkg::TSC_OP_ADJ, 16'h0011, 16'h0003, 4'h0);
    chk("adjust up", 32'h10013, {15'h0, trsp.zf, trsp.result});
    do_test(tsc_pkg::TSC_OP_ADJ, 16'h0013, 16'h0001, 4'h0);
    chk("adjust keep", 32'h00013, {15'h0, trsp.zf, trsp.result});
    do_test(tsc_pkg::TSC_OP_VRD, 16'h0010, 16'h0, 4'h2);
    chk("verify read", 32'h1, {31'h0, trsp.zf});
    do_test(tsc_pkg::TSC_OP_VWR, 16'h0010, 16'h0, 4'h2);
    chk("verify write", 32'h0, {31'h0, trsp.zf});
    do_test(tsc_pkg::TSC_OP_LIM, 16'h0010, 16'h0, 4'hc);
    chk("limit load", 32'h11234, {15'h0, trsp.zf, trsp.result});
    do_test(tsc_pkg::TSC_OP_LIM, 16'h0010, 16'h0, 4'h8);
    chk("limit refused", 32'h0, {31'h0, trsp.zf});
    do_test(tsc_pkg::TSC_OP_RIGHTS, 16'h0010, 16'h0, 4'h8);
    chk("rights load", 32'h19300, {15'h0, trsp.zf, trsp.result});
    $display("test pointer done");
  endtask : t_ptr

  task automatic t_fault();
    @(posedge clk);
    swl_val <= 4'h1;
    pulse(2);
    do_sw(tsc_pkg::TSC_SRC_JMP, 16'h0040, 16'h002c, 1'b0, 1'b0);
    chk("initial jump", 32'h1, {31'h0, switch_go});
    do_sw(tsc_pkg::TSC_SRC_JMP, 16'h0040, 16'h002c, 1'b1, 1'b0);
    chk("busy ref", 32'h10d, {23'h0, exc_valid, exc_vector});
    enter_shut();
    do_sw(tsc_pkg::TSC_SRC_CALL, 16'h0048, 16'h002c, 1'b0, 1'b0);
    chk("frozen", 32'h0, {31'h0, switch_go});
    @(posedge clk);
    nmi <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk("nmi exit", 32'h1, {30'h0, shutdown, stw[0]});
    @(posedge clk);
    nmi <= 1'b0;
    enter_shut();
    @(posedge clk);
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    #1;
    chk("reset exit", 32'h0, {30'h0, shutdown, stw[0]});
    $display("test fault done");
  endtask : t_fault

  //////////////////////////////////////////////////////////////////////////////
  // Main sequence: idle inputs, reset for ten cycles, then each scenario.
  initial begin
    srst = 1'b1;
    sreq = '0;
    treq = '0;
    {plain_int, target_busy, fw, swl, ext_op, exception_in, nmi, cs_load} = 8'h00;
    fw_val = 16'h0000;
    swl_val = 4'h0;
    seg_sel = 2'h1;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    #1;
    t_reset();
    t_switch();
    t_nested();
    t_ext();
    t_ptr();
    t_fault();
    complete_run();
  end
endmodule : tsc_task_switch_control_test
`default_nettype wire
